// *** core/dual_uart.sv ***
// dual asynchronous serial channel: host register access, fifos, framing and pins
// assumes host strobes are synchronous to clock and held low at least one clock
//
// Contract
// - mcr bit 1 set drives that channel's request-to-send low
// - request-to-send reads high after reset
// - loopback feeds own transmit stream into receiver, ignoring receive pin
// - transmit pin high in reset, idle, or when transmitter not sending
// - loopback holds the transmit pin inactive high
// - transmit-ready low while any transmit fifo or holding slot free
// - chip select high ignores all; channel pick high is A, low B
// - afr bit 0 of the picked channel makes writes update both channels
// - characters framed with start and stop bits; receiver syncs on them
// - optional parity appended on send and checked on receive
// - each channel has 16-byte transmit and receive fifos
// - four selectable receive fill thresholds raise a level flag
// - read strobe fall loads addressed register onto read data
// - write strobe fall stores data into addressed register
// - divisor latches and afr reachable only with lcr bit 7 set
`timescale 1ns/1ps
module dual_uart (
   input wire logic clock,
   input wire logic nrst,
   input wire uart_pkg::host_bus_t host,
   output logic [7:0] read_data,
   input wire logic [1:0] serial_in,
   output logic [1:0] serial_out,
   output logic [1:0] request_send_out_n,
   output logic [1:0] tx_space_flag_n,
   output logic [1:0] rx_level_reached
);

   // mask of valid data bits for a character length code
   function automatic logic [7:0] data_mask(input logic [1:0] len);
      data_mask = 8'hff >> (2'h3 - len);
   endfunction : data_mask

   // parity bit for the masked data, even or odd
   function automatic logic parity_of(input logic [7:0] d, input logic even);
      parity_of = even ? ^d : ~^d;
   endfunction : parity_of

   ////////////////////////////////////////////////////////////////////////////
   // strobe edge detection and channel decode

   logic rd_prev_q;
   logic wr_prev_q;
   logic rd_fall;
   logic wr_fall;
   logic sel;
   logic [1:0] bcast;
   logic [1:0][7:0] ch_rd;
   logic [7:0] read_data_q;

   // previous strobe levels, idle high
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rd_prev_q <= 1'b1;
         wr_prev_q <= 1'b1;
      end else begin
         rd_prev_q <= host.read_strobe_n;
         wr_prev_q <= host.write_strobe_n;
      end
   end

   assign rd_fall = rd_prev_q & ~host.read_strobe_n & ~host.cs_n;
   assign wr_fall = wr_prev_q & ~host.write_strobe_n & ~host.cs_n;
   assign sel = ~host.channel_pick; // index 0 is channel A

   // read data latched from the picked channel only
   always_ff @(posedge clock) begin
      if (!nrst) begin
         read_data_q <= uart_pkg::REG_RESET;
      end else if (rd_fall) begin
         read_data_q <= ch_rd[sel];
      end
   end
   assign read_data = read_data_q;

   ////////////////////////////////////////////////////////////////////////////
   // per-channel logic

   for (genvar c = 0; c < uart_pkg::CHANNELS; c++) begin : g_ch
      logic [7:0] lcr_q, mcr_q, fcr_q, ier_q, spr_q, dll_q, dlm_q, afr_q;
      logic [7:0] lsr;
      logic [2:0] err_q; // overrun, parity, framing
      logic wr_hit, rd_hit, dlab;
      logic [7:0] txm [uart_pkg::FIFO_DEPTH];
      logic [7:0] rxm [uart_pkg::FIFO_DEPTH];
      logic [3:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
      logic [4:0] tx_cnt_q, rx_cnt_q, cap;
      logic tx_push, tx_pop, rx_push, rx_pop, rx_full;
      logic [15:0] baud_q, div;
      logic tick;
      uart_pkg::tx_state_t tx_st_q;
      logic [11:0] tx_sh_q, frame;
      logic [3:0] tx_tick_q, tx_idx_q, nbits, tx_last, rx_last;
      logic tx_line, rx_line;
      uart_pkg::rx_state_t rx_st_q;
      logic [11:0] rx_sh_q;
      logic [3:0] rx_tick_q, rx_idx_q;
      logic [7:0] rx_data;
      logic par_en;

      assign dlab = lcr_q[uart_pkg::LCR_DLAB];
      assign bcast[c] = afr_q[uart_pkg::AFR_BCAST];
      assign wr_hit = wr_fall & ((sel == c) | bcast[sel]);
      assign rd_hit = rd_fall & (sel == c);
      assign cap = fcr_q[uart_pkg::FCR_FIFO_EN] ? uart_pkg::CAP_FIFO : uart_pkg::CAP_BYTE;
      assign par_en = lcr_q[uart_pkg::LCR_PAR_EN];
      assign nbits = uart_pkg::BASE_BITS + {2'b00, lcr_q[1:0]};

      // configuration registers; divisor set only behind lcr bit 7
      always_ff @(posedge clock) begin
         if (!nrst) begin
            lcr_q <= uart_pkg::REG_RESET;
            mcr_q <= uart_pkg::REG_RESET;
            fcr_q <= uart_pkg::REG_RESET;
            ier_q <= uart_pkg::REG_RESET;
            spr_q <= uart_pkg::REG_RESET;
            dll_q <= uart_pkg::DLL_RESET;
            dlm_q <= uart_pkg::REG_RESET;
            afr_q <= uart_pkg::REG_RESET;
         end else if (wr_hit) begin
            if (dlab) begin
               case (host.addr)
                  uart_pkg::REG_DLL: dll_q <= host.wdata;
                  uart_pkg::REG_DLM: dlm_q <= host.wdata;
                  uart_pkg::REG_AFR: afr_q <= host.wdata;
                  uart_pkg::REG_LCR: lcr_q <= host.wdata;
                  uart_pkg::REG_MCR: mcr_q <= host.wdata;
                  uart_pkg::REG_SPR: spr_q <= host.wdata;
                  default: ;
               endcase
            end else begin
               case (host.addr)
                  uart_pkg::REG_IER: ier_q <= host.wdata & uart_pkg::IER_MASK;
                  uart_pkg::REG_ISR_FCR: fcr_q <= host.wdata;
                  uart_pkg::REG_LCR: lcr_q <= host.wdata;
                  uart_pkg::REG_MCR: mcr_q <= host.wdata;
                  uart_pkg::REG_SPR: spr_q <= host.wdata;
                  default: ;
               endcase
            end
         end
      end

      // register read mux
      always_comb begin
         ch_rd[c] = uart_pkg::REG_RESET;
         case (host.addr)
            uart_pkg::REG_DATA: ch_rd[c] = dlab ? dll_q : rxm[rx_rp_q];
            uart_pkg::REG_IER: ch_rd[c] = dlab ? dlm_q : ier_q;
            uart_pkg::REG_ISR_FCR: ch_rd[c] = dlab ? afr_q : uart_pkg::ISR_NONE;
            uart_pkg::REG_LCR: ch_rd[c] = lcr_q;
            uart_pkg::REG_MCR: ch_rd[c] = mcr_q;
            uart_pkg::REG_LSR: ch_rd[c] = lsr;
            uart_pkg::REG_MSR: ch_rd[c] = uart_pkg::REG_RESET;
            uart_pkg::REG_SPR: ch_rd[c] = spr_q;
            default: ch_rd[c] = uart_pkg::REG_RESET;
         endcase
      end

      // line status, error bits cleared by reading it
      always_comb begin
         lsr = uart_pkg::REG_RESET;
         lsr[uart_pkg::LSR_DR] = (rx_cnt_q != 5'h00);
         lsr[uart_pkg::LSR_OE] = err_q[2];
         lsr[uart_pkg::LSR_PE] = err_q[1];
         lsr[uart_pkg::LSR_FE] = err_q[0];
         lsr[uart_pkg::LSR_THRE] = (tx_cnt_q == 5'h00);
         lsr[uart_pkg::LSR_TEMT] = (tx_cnt_q == 5'h00) && (tx_st_q == uart_pkg::TX_IDLE);
      end

      // 16x tick from the divisor latch, zero treated as one
      assign div = ({dlm_q, dll_q} == 16'h0000) ? 16'h0001 : {dlm_q, dll_q};
      assign tick = (baud_q >= div - 16'h0001);
      always_ff @(posedge clock) begin
         if (!nrst) baud_q <= 16'h0000;
         else baud_q <= tick ? 16'h0000 : baud_q + 16'h0001;
      end

      // transmit fifo, 16 deep or a single holding byte
      assign tx_push = wr_hit && !dlab && (host.addr == uart_pkg::REG_DATA) && (tx_cnt_q < cap);
      assign tx_pop = (tx_st_q == uart_pkg::TX_IDLE) && (tx_cnt_q != 5'h00);
      always_ff @(posedge clock) begin
         if (tx_push) txm[tx_wp_q] <= host.wdata;
      end
      always_ff @(posedge clock) begin
         if (!nrst || (wr_hit && !dlab && host.addr == uart_pkg::REG_ISR_FCR
                       && host.wdata[uart_pkg::FCR_TX_CLR])) begin
            tx_wp_q <= 4'h0;
            tx_rp_q <= 4'h0;
            tx_cnt_q <= 5'h00;
         end else begin
            tx_wp_q <= tx_wp_q + {3'h0, tx_push};
            tx_rp_q <= tx_rp_q + {3'h0, tx_pop};
            tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
         end
      end
      assign tx_space_flag_n[c] = ~(tx_cnt_q < cap);

      // outgoing frame: start, data, optional parity, one or two stops
      always_comb begin
         frame = 12'hfff;
         frame[0] = 1'b0;
         frame[8:1] = (txm[tx_rp_q] & data_mask(lcr_q[1:0])) | ~data_mask(lcr_q[1:0]);
         if (par_en) frame[nbits + 4'h1] = parity_of(txm[tx_rp_q] & data_mask(lcr_q[1:0]),
                                                     lcr_q[uart_pkg::LCR_PAR_EVEN]);
      end
      assign tx_last = nbits + {3'h0, par_en} + {3'h0, lcr_q[uart_pkg::LCR_STOP2]} + 4'h1;

      // transmit shifter
      always_ff @(posedge clock) begin
         if (!nrst) begin
            tx_st_q <= uart_pkg::TX_IDLE;
            tx_sh_q <= 12'hfff;
            tx_tick_q <= 4'h0;
            tx_idx_q <= 4'h0;
         end else begin
            case (tx_st_q)
               uart_pkg::TX_IDLE: begin
                  if (tx_pop) begin
                     tx_st_q <= uart_pkg::TX_SEND;
                     tx_sh_q <= frame;
                     tx_tick_q <= 4'h0;
                     tx_idx_q <= 4'h0;
                  end
               end
               uart_pkg::TX_SEND: begin
                  if (tick) begin
                     tx_tick_q <= tx_tick_q + 4'h1;
                     if (tx_tick_q == uart_pkg::TICK_LAST) begin
                        tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                        tx_idx_q <= tx_idx_q + 4'h1;
                        if (tx_idx_q == tx_last) tx_st_q <= uart_pkg::TX_IDLE;
                     end
                  end
               end
               default: tx_st_q <= uart_pkg::TX_IDLE;
            endcase
         end
      end
      assign tx_line = (tx_st_q == uart_pkg::TX_SEND) ? tx_sh_q[0] : 1'b1;

      // pins and loopback routing
      assign serial_out[c] = mcr_q[uart_pkg::MCR_LOOP] ? 1'b1 : tx_line;
      assign rx_line = mcr_q[uart_pkg::MCR_LOOP] ? tx_line : serial_in[c];
      assign request_send_out_n[c] = ~mcr_q[uart_pkg::MCR_RTS];

      // receiver: start found at low, checked mid-bit, then one sample per bit
      assign rx_last = nbits + {3'h0, par_en};
      always_ff @(posedge clock) begin
         if (!nrst) begin
            rx_st_q <= uart_pkg::RX_IDLE;
            rx_sh_q <= 12'h000;
            rx_tick_q <= 4'h0;
            rx_idx_q <= 4'h0;
         end else begin
            case (rx_st_q)
               uart_pkg::RX_IDLE: begin
                  rx_tick_q <= 4'h0;
                  rx_idx_q <= 4'h0;
                  if (tick && !rx_line) rx_st_q <= uart_pkg::RX_START;
               end
               uart_pkg::RX_START: begin
                  if (tick) begin
                     rx_tick_q <= rx_tick_q + 4'h1;
                     if (rx_tick_q == uart_pkg::TICK_HALF) begin
                        rx_tick_q <= 4'h0;
                        rx_st_q <= rx_line ? uart_pkg::RX_IDLE : uart_pkg::RX_BITS;
                     end
                  end
               end
               uart_pkg::RX_BITS: begin
                  if (tick) begin
                     rx_tick_q <= rx_tick_q + 4'h1;
                     if (rx_tick_q == uart_pkg::TICK_LAST) begin
                        rx_sh_q[rx_idx_q] <= rx_line;
                        rx_idx_q <= rx_idx_q + 4'h1;
                        if (rx_idx_q == rx_last) rx_st_q <= uart_pkg::RX_DONE;
                     end
                  end
               end
               uart_pkg::RX_DONE: rx_st_q <= uart_pkg::RX_IDLE;
               default: rx_st_q <= uart_pkg::RX_IDLE;
            endcase
         end
      end
      assign rx_data = rx_sh_q[7:0] & data_mask(lcr_q[1:0]);

      // receive fifo and sticky errors; a new error wins over the clearing read
      assign rx_full = (rx_cnt_q >= cap);
      assign rx_push = (rx_st_q == uart_pkg::RX_DONE) && !rx_full;
      assign rx_pop = rd_hit && !dlab && (host.addr == uart_pkg::REG_DATA) && (rx_cnt_q != 5'h00);
      always_ff @(posedge clock) begin
         if (rx_push) rxm[rx_wp_q] <= rx_data;
      end
      always_ff @(posedge clock) begin
         if (!nrst || (wr_hit && !dlab && host.addr == uart_pkg::REG_ISR_FCR
                       && host.wdata[uart_pkg::FCR_RX_CLR])) begin
            rx_wp_q <= 4'h0;
            rx_rp_q <= 4'h0;
            rx_cnt_q <= 5'h00;
         end else begin
            rx_wp_q <= rx_wp_q + {3'h0, rx_push};
            rx_rp_q <= rx_rp_q + {3'h0, rx_pop};
            rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
         end
      end
      always_ff @(posedge clock) begin
         if (!nrst) begin
            err_q <= 3'h0;
         end else begin
            if (rd_hit && host.addr == uart_pkg::REG_LSR) err_q <= 3'h0;
            if (rx_st_q == uart_pkg::RX_DONE) begin
               if (rx_full) err_q[2] <= 1'b1;
               if (par_en && (rx_sh_q[nbits] != parity_of(rx_data,
                              lcr_q[uart_pkg::LCR_PAR_EVEN]))) err_q[1] <= 1'b1;
               if (!rx_sh_q[rx_last]) err_q[0] <= 1'b1;
            end
         end
      end

      // fill threshold flag, chosen by fcr bits 7:6 in fifo mode
      assign rx_level_reached[c] = fcr_q[uart_pkg::FCR_FIFO_EN]
         ? (rx_cnt_q >= uart_pkg::RX_TRIG[fcr_q[7:6]]) : (rx_cnt_q != 5'h00);
   end

endmodule : dual_uart

// *** core/uart_pkg.sv ***
// shared constants, types and state encodings for the dual serial channel core
// assumes one synchronous clock domain and a host bus already sampled to that clock
package uart_pkg;

   localparam int unsigned CHANNELS = 2;
   localparam int unsigned FIFO_DEPTH = 16;

   // register offsets, general set
   localparam logic [2:0] REG_DATA = 3'h0;
   localparam logic [2:0] REG_IER = 3'h1;
   localparam logic [2:0] REG_ISR_FCR = 3'h2;
   localparam logic [2:0] REG_LCR = 3'h3;
   localparam logic [2:0] REG_MCR = 3'h4;
   localparam logic [2:0] REG_LSR = 3'h5;
   localparam logic [2:0] REG_MSR = 3'h6;
   localparam logic [2:0] REG_SPR = 3'h7;
   // register offsets, divisor set (line control bit 7 high)
   localparam logic [2:0] REG_DLL = 3'h0;
   localparam logic [2:0] REG_DLM = 3'h1;
   localparam logic [2:0] REG_AFR = 3'h2;

   // field positions
   localparam int unsigned LCR_STOP2 = 2;
   localparam int unsigned LCR_PAR_EN = 3;
   localparam int unsigned LCR_PAR_EVEN = 4;
   localparam int unsigned LCR_DLAB = 7;
   localparam int unsigned MCR_RTS = 1;
   localparam int unsigned MCR_LOOP = 4;
   localparam int unsigned AFR_BCAST = 0;
   localparam int unsigned FCR_FIFO_EN = 0;
   localparam int unsigned FCR_RX_CLR = 1;
   localparam int unsigned FCR_TX_CLR = 2;
   localparam int unsigned LSR_DR = 0;
   localparam int unsigned LSR_OE = 1;
   localparam int unsigned LSR_PE = 2;
   localparam int unsigned LSR_FE = 3;
   localparam int unsigned LSR_THRE = 5;
   localparam int unsigned LSR_TEMT = 6;

   // reset and fixed read values
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] DLL_RESET = 8'h01;
   localparam logic [7:0] ISR_NONE = 8'h01;
   localparam logic [7:0] IER_MASK = 8'h0f;

   // bit timing in 16x ticks and character shape
   localparam logic [3:0] TICK_LAST = 4'hf;
   localparam logic [3:0] TICK_HALF = 4'h7;
   localparam logic [3:0] BASE_BITS = 4'h5;
   localparam logic [4:0] CAP_BYTE = 5'h01;
   localparam logic [4:0] CAP_FIFO = 5'h10;
   localparam logic [4:0] RX_TRIG [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};

   // host parallel bus, one sample per clock
   typedef struct packed {
      logic cs_n;
      logic channel_pick;
      logic [2:0] addr;
      logic read_strobe_n;
      logic write_strobe_n;
      logic [7:0] wdata;
   } host_bus_t;

   typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b11, RX_DONE = 2'b10
   } rx_state_t;

endpackage : uart_pkg

// *** tb/far_serial.sv ***
// far serial device model: drives both receive lines of the core
// assumes divisor 1, so one bit lasts 16 clocks, and 8 data bits with no parity
`timescale 1ns/1ps
module far_serial (
   input wire logic clock,
   output logic [1:0] line
);
   ////////////////////////////////////////////////////////////////////////////
   // idle lines rest high until a frame is sent
   initial begin
      line = 2'b11;
   end

   // one frame: start low, data lsb first, stop high, then back to idle
   task send(input int ch, input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clock);
         #1 line[ch] = f[i];
         repeat (15) @(posedge clock);
      end
   endtask : send
endmodule : far_serial

// *** tb/dual_uart_chk.sv ***
// port checker for the dual serial core
// assumes one clock and a synchronous active-low reset, bound from tb_top
`timescale 1ns/1ps
module dual_uart_chk (
   input wire logic clock,
   input wire logic nrst,
   input wire uart_pkg::host_bus_t host,
   input wire logic [7:0] read_data,
   input wire logic [1:0] serial_in,
   input wire logic [1:0] serial_out,
   input wire logic [1:0] request_send_out_n,
   input wire logic [1:0] tx_space_flag_n,
   input wire logic [1:0] rx_level_reached
);
   logic rd_q;
   logic wr_q;
   logic take_r;
   logic take_w;

   ////////////////////////////////////////////////////////////////////////////
   // strobe history, so an access is counted once per falling strobe
   always_ff @(posedge clock) begin
      rd_q <= host.read_strobe_n;
      wr_q <= host.write_strobe_n;
   end
   assign take_r = !host.cs_n && !host.read_strobe_n && rd_q;
   assign take_w = !host.cs_n && !host.write_strobe_n && wr_q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   ////////////////////////////////////////////////////////////////////////////
   // pin levels and register effects
   reset_vals_a: assert property ($rose(nrst) |-> serial_out == 2'b11
      && request_send_out_n == 2'b11 && tx_space_flag_n == 2'b00 && read_data == 8'h00)
      else $error("outputs wrong after reset");
   rts_a_a: assert property (take_w && host.channel_pick && host.addr == 3'h4
      |=> request_send_out_n[0] == !$past(host.wdata[uart_pkg::MCR_RTS]))
      else $error("channel a rts does not follow write");
   rts_b_a: assert property (take_w && !host.channel_pick && host.addr == 3'h4
      |=> request_send_out_n[1] == !$past(host.wdata[uart_pkg::MCR_RTS]))
      else $error("channel b rts does not follow write");
   rts_hold_a: assert property ($changed(request_send_out_n) |-> $past(take_w))
      else $error("rts moved without a write");
   rdata_hold_a: assert property ($changed(read_data) |-> $past(take_r))
      else $error("read data moved without a read");
   space_rise_a: assert property ($rose(tx_space_flag_n[0]) || $rose(tx_space_flag_n[1])
      |-> $past(take_w))
      else $error("transmit space flag rose without a write");
   start_bit_a: assert property ($fell(serial_out[0]) |-> !serial_out[0] [*8])
      else $error("start bit too short");
   rx_drop_a: assert property ($fell(rx_level_reached[0]) |-> $past(take_r || take_w))
      else $error("receive level dropped without host access");

   // main scenarios reached
   cover property (take_w && host.addr == 3'h4);
   cover property ($fell(serial_out[0]));
   cover property ($rose(rx_level_reached[1]));
endmodule : dual_uart_chk

// *** tb/tb_top.sv ***
// self-checking bench for the dual serial core, registers driven as plain ports
// assumes far_serial on the receive lines and dual_uart_chk bound to the core
`timescale 1ns/1ps
module tb_top;
   logic clock;
   logic nrst;
   uart_pkg::host_bus_t host;
   logic [7:0] read_data;
   logic [1:0] serial_in;
   logic [1:0] serial_out;
   logic [1:0] request_send_out_n;
   logic [1:0] tx_space_flag_n;
   logic [1:0] rx_level_reached;
   logic cs_off;
   logic [7:0] v;
   logic [7:0] q;
   int failures;
   int check_count;
   int n;

   dual_uart dut_u (.clock(clock), .nrst(nrst), .host(host), .read_data(read_data),
      .serial_in(serial_in), .serial_out(serial_out),
      .request_send_out_n(request_send_out_n), .tx_space_flag_n(tx_space_flag_n),
      .rx_level_reached(rx_level_reached));
   far_serial far_u (.clock(clock), .line(serial_in));

   always #5 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////
   // verdict, compare and bus cycle helpers
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task acc(input logic w, input logic ch, input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 host = '{cs_off, ch, a, w, !w, d};
      @(posedge clock);
      #1 host = '{1'b1, ch, a, 1'b1, 1'b1, d};
   endtask : acc

   task wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
      acc(1'b1, ch, a, d);
   endtask : wr

   task rd(input logic ch, input logic [2:0] a);
      acc(1'b0, ch, a, 8'h00);
      @(posedge clock);
      #1 q = read_data;
   endtask : rd

   // decodes one frame of v on serial_out[ch], optional even parity
   task get_frame(input int ch, input logic par);
      for (n = 0; n < 400 && serial_out[ch] !== 1'b0; n++) begin
         @(posedge clock);
         #1;
      end
      if (n == 400) begin
         failures++;
         finish_test();
      end
      repeat (8) @(posedge clock);
      #1 chk({7'h0, serial_out[ch]}, 8'h00);
      for (int i = 0; i < 8 + par; i++) begin
         repeat (16) @(posedge clock);
         #1 chk({7'h0, serial_out[ch]}, {7'h0, (i == 8) ? ^v : v[i]});
      end
      repeat (16) @(posedge clock);
      #1 chk({7'h0, serial_out[ch]}, 8'h01);
      repeat (16) @(posedge clock);
   endtask : get_frame

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_rts;
      wr(1'b1, 3'h4, 8'h02);
      chk({6'h0, request_send_out_n}, 8'h02);
      wr(1'b0, 3'h4, 8'h02);
      chk({6'h0, request_send_out_n}, 8'h00);
      cs_off = 1'b1;
      wr(1'b1, 3'h4, 8'h00);
      cs_off = 1'b0;
      chk({6'h0, request_send_out_n}, 8'h00);
      wr(1'b1, 3'h4, 8'h00);
      wr(1'b0, 3'h4, 8'h00);
      chk({6'h0, request_send_out_n}, 8'h03);
      $display("test rts done");
   endtask : t_rts

   task t_bcast;
      wr(1'b1, 3'h3, 8'h80);
      rd(1'b1, 3'h0);
      chk(q, uart_pkg::DLL_RESET);
      wr(1'b1, 3'h2, 8'h01);
      wr(1'b1, 3'h3, 8'h03);
      wr(1'b1, 3'h4, 8'h02);
      chk({6'h0, request_send_out_n}, 8'h00);
      wr(1'b1, 3'h7, 8'ha5);
      wr(1'b1, 3'h3, 8'h80);
      // broadcast still on: each read shows only the picked channel's afr
      rd(1'b0, 3'h2);
      chk(q, 8'h00);
      rd(1'b1, 3'h2);
      chk(q, 8'h01);
      wr(1'b1, 3'h2, 8'h00);
      wr(1'b1, 3'h3, 8'h03);
      wr(1'b0, 3'h3, 8'h03);
      wr(1'b0, 3'h7, 8'h3c);
      rd(1'b1, 3'h7);
      chk(q, 8'ha5);
      rd(1'b0, 3'h7);
      chk(q, 8'h3c);
      wr(1'b1, 3'h4, 8'h00);
      wr(1'b0, 3'h4, 8'h00);
      $display("test broadcast done");
   endtask : t_bcast

   task t_frame;
      v = 8'h35;
      wr(1'b1, 3'h0, v);
      chk({7'h0, tx_space_flag_n[0]}, 8'h01);
      get_frame(0, 1'b0);
      chk({6'h0, tx_space_flag_n}, 8'h00);
      wr(1'b1, 3'h3, 8'h1b);
      v = 8'h07;
      wr(1'b1, 3'h0, v);
      get_frame(0, 1'b1);
      $display("test frame done");
   endtask : t_frame

   task t_loop;
      int bad;
      bad = 0;
      wr(1'b1, 3'h4, 8'h10);
      wr(1'b1, 3'h0, 8'h96);
      repeat (300) begin
         @(posedge clock);
         #1 bad += (serial_out !== 2'b11);
      end
      chk(bad[7:0], 8'h00);
      chk({6'h0, rx_level_reached}, 8'h01);
      rd(1'b1, 3'h0);
      chk(q, 8'h96);
      wr(1'b1, 3'h4, 8'h00);
      $display("test loopback done");
   endtask : t_loop

   task t_rx;
      // channel b expects even parity; the far frame has none, so its stop lands as parity
      wr(1'b0, 3'h3, 8'h1b);
      far_u.send(1, 8'hc3);
      for (n = 0; n < 100 && rx_level_reached[1] !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      chk({7'h0, rx_level_reached[1]}, 8'h01);
      rd(1'b0, 3'h0);
      chk(q, 8'hc3);
      chk({6'h0, rx_level_reached}, 8'h00);
      rd(1'b0, 3'h5);
      chk(q, 8'h64);
      rd(1'b0, 3'h5);
      chk(q, 8'h60);
      $display("test receive done");
   endtask : t_rx

   task t_fifo;
      wr(1'b1, 3'h2, 8'h01);
      for (int i = 0; i < 16; i++) begin
         wr(1'b1, 3'h0, i[7:0]);
      end
      chk({7'h0, tx_space_flag_n[0]}, 8'h00);
      wr(1'b1, 3'h0, 8'h10);
      chk({7'h0, tx_space_flag_n[0]}, 8'h01);
      $display("test fifo done");
   endtask : t_fifo

   ////////////////////////////////////////////////////////////////////////////
   // reset, then the scenarios in turn
   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      cs_off = 1'b0;
      host = '{1'b1, 1'b0, 3'h0, 1'b1, 1'b1, 8'h00};
      failures = 0;
      check_count = 0;
      repeat (5) @(posedge clock);
      #1 nrst = 1'b1;
      chk({serial_out, request_send_out_n, tx_space_flag_n, rx_level_reached}, 8'hf0);
      chk(read_data, 8'h00);
      $display("test reset done");
      t_rts();
      t_bcast();
      t_frame();
      t_loop();
      t_rx();
      t_fifo();
      finish_test();
   end
endmodule : tb_top

bind dual_uart dual_uart_chk chk_u (.clock(clock), .nrst(nrst), .host(host),
   .read_data(read_data), .serial_in(serial_in), .serial_out(serial_out),
   .request_send_out_n(request_send_out_n), .tx_space_flag_n(tx_space_flag_n),
   .rx_level_reached(rx_level_reached));
